// *** rtl/fbms_boot_ctrl.sv ***
// Purpose: Boot mode capture, serial programming link and flash area guard.
// Assumes: Pins are asynchronous to sys_clk; link clock well below sys_clk/8.
// Notes: Received bytes pass a FIFO with a registered output stage.
`timescale 1ns/100ps

module fbms_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Fill side.
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side.
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;
	assign in_ready = (count_r != (AW+1)'(DEPTH));
	assign push = in_valid && in_ready;
	// The output stage refills whenever it is empty or being taken.
	assign pop = (count_r != '0) && (!out_valid || out_ready);
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			out_valid <= 1'b0;
			out_data <= '0;
		end else if (pop) begin
			out_valid <= 1'b1;
			out_data <= mem_r[rd_ptr_r];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end
endmodule // fbms_fifo

module fbms_boot_ctrl
	import fbms_pkg::*;
#(
	parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEF,
	parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF,
	parameter int unsigned ADDR_W = 16,
	parameter logic [ADDR_W-1:0] USER_BASE = 16'h8000,
	parameter logic [ADDR_W-1:0] BOOT_BASE = 16'hF000
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Boot and link pins.
	input wire logic boot_select_pin,
	input wire logic serial_clock_pin,
	input wire logic serial_receive_pin,
	output logic serial_transmit_pin_r,
	output logic busy_pin_r,
	output logic busy_pin_oe_r,
	// Captured mode.
	output logic mode_valid_r,
	output logic mode_serial_r,
	output logic mode_sync_r,
	// Received bytes towards the core.
	output logic rx_valid_r,
	output logic [DATA_W-1:0] rx_data_r,
	input wire logic rx_ready,
	// Bytes from the core to send.
	input wire logic tx_valid,
	input wire logic [DATA_W-1:0] tx_data,
	output logic tx_ready_r,
	// Flash rewrite requests from the core.
	input wire logic fl_req,
	input wire logic fl_erase,
	input wire logic [ADDR_W-1:0] fl_addr,
	output logic fl_go_r,
	output logic fl_erase_all_r,
	output logic fl_reject_r
);
	localparam int unsigned BW = $clog2(BIT_CYCLES + 1);
	localparam logic [BW-1:0] BIT_LAST = BW'(BIT_CYCLES - 1);
	localparam logic [BW-1:0] HALF_BIT = BW'(BIT_CYCLES / 2);

	logic [NUM_PINS-1:0] pins;
	logic [NUM_PINS-1:0] s1_r;
	logic [NUM_PINS-1:0] s2_r;
	logic [NUM_PINS-1:0] s3_r;
	logic [NUM_PINS-1:0] flt_r;
	logic clk_prev_r;
	logic clk_rise;
	logic clk_fall;
	logic link_on;
	fbms_md_e md_r;
	logic [3:0] settle_r;
	fbms_rx_e rx_st_r;
	logic [BW-1:0] rx_tmr_r;
	logic [3:0] rx_cnt_r;
	logic [DATA_W-1:0] rx_sh_r;
	logic push_r;
	logic [DATA_W-1:0] push_data_r;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [DATA_W-1:0] fifo_out_data;
	logic [BW-1:0] tx_tmr_r;
	logic [3:0] tx_cnt_r;
	logic [ASYNC_FRAME_BITS-1:0] tx_sh_r;
	logic tx_tick;
	logic tx_load;
	logic in_user;
	logic in_boot;

	assign pins = {serial_receive_pin, serial_clock_pin, boot_select_pin};

	// Three stages per pin; a level counts only when stages two and three agree.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					s1_r[gi] <= 1'b0;
					s2_r[gi] <= 1'b0;
					s3_r[gi] <= 1'b0;
					flt_r[gi] <= 1'b0;
				end else begin
					s1_r[gi] <= pins[gi];
					s2_r[gi] <= s1_r[gi];
					s3_r[gi] <= s2_r[gi];
					if (s2_r[gi] == s3_r[gi]) begin
						flt_r[gi] <= s3_r[gi];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			clk_prev_r <= 1'b0;
		end else begin
			clk_prev_r <= flt_r[PIN_CLK];
		end
	end
	assign clk_rise = flt_r[PIN_CLK] && !clk_prev_r;
	assign clk_fall = !flt_r[PIN_CLK] && clk_prev_r;

	// Pins are captured once, after the synchronisers have settled past release.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			md_r <= FBMS_MD_SETTLE;
			settle_r <= '0;
			mode_valid_r <= 1'b0;
			mode_serial_r <= 1'b0;
			mode_sync_r <= 1'b0;
		end else begin
			unique case (md_r)
				FBMS_MD_SETTLE: begin
					settle_r <= settle_r + 1'b1;
					if (settle_r == SETTLE_CYCLES) begin
						md_r <= FBMS_MD_RUN;
						mode_valid_r <= 1'b1;
						mode_serial_r <= flt_r[PIN_BOOT];
						mode_sync_r <= flt_r[PIN_BOOT] && flt_r[PIN_CLK];
					end
				end
				FBMS_MD_RUN: begin
					md_r <= FBMS_MD_RUN;
				end
			endcase
		end
	end

	// The serial channel exists only for programming traffic.
	assign link_on = mode_valid_r && mode_serial_r;

	// Receive path: clock edges in synchronous mode, bit timer otherwise.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_st_r <= FBMS_RX_IDLE;
			rx_tmr_r <= '0;
			rx_cnt_r <= '0;
			rx_sh_r <= '0;
			push_r <= 1'b0;
			push_data_r <= '0;
		end else begin
			push_r <= 1'b0;
			unique case (rx_st_r)
				FBMS_RX_IDLE: begin
					rx_cnt_r <= '0;
					rx_tmr_r <= '0;
					if (link_on && mode_sync_r) begin
						rx_st_r <= FBMS_RX_DATA;
					end else if (link_on && !flt_r[PIN_RX]) begin
						rx_st_r <= FBMS_RX_START;
					end
				end
				FBMS_RX_START: begin
					rx_tmr_r <= rx_tmr_r + 1'b1;
					if (rx_tmr_r == HALF_BIT) begin
						rx_tmr_r <= '0;
						rx_st_r <= flt_r[PIN_RX] ? FBMS_RX_IDLE : FBMS_RX_DATA;
					end
				end
				FBMS_RX_DATA: begin
					if (mode_sync_r) begin
						if (clk_rise) begin
							rx_sh_r <= {flt_r[PIN_RX], rx_sh_r[DATA_W-1:1]};
							rx_cnt_r <= rx_cnt_r + 1'b1;
							if (rx_cnt_r == SYNC_FRAME_BITS - 1'b1) begin
								rx_cnt_r <= '0;
								push_r <= 1'b1;
								push_data_r <= {flt_r[PIN_RX], rx_sh_r[DATA_W-1:1]};
							end
						end
					end else begin
						rx_tmr_r <= rx_tmr_r + 1'b1;
						if (rx_tmr_r == BIT_LAST) begin
							rx_tmr_r <= '0;
							rx_sh_r <= {flt_r[PIN_RX], rx_sh_r[DATA_W-1:1]};
							rx_cnt_r <= rx_cnt_r + 1'b1;
							if (rx_cnt_r == SYNC_FRAME_BITS - 1'b1) begin
								rx_st_r <= FBMS_RX_STOP;
							end
						end
					end
				end
				FBMS_RX_STOP: begin
					rx_tmr_r <= rx_tmr_r + 1'b1;
					if (rx_tmr_r == BIT_LAST) begin
						rx_st_r <= FBMS_RX_IDLE;
						// A byte with a bad stop bit is dropped.
						push_r <= flt_r[PIN_RX];
						push_data_r <= rx_sh_r;
					end
				end
				default: begin
					rx_st_r <= FBMS_RX_IDLE;
				end
			endcase
		end
	end

	// Received bytes wait here for the core, which drains them itself.
	fbms_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(push_r),
		.in_data(push_data_r),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(rx_ready && rx_valid_r)
	);

	// A one-deep output register keeps the core port straight off flops.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_valid_r <= 1'b0;
			rx_data_r <= '0;
		end else if (!rx_valid_r || rx_ready) begin
			rx_valid_r <= fifo_out_valid && !(rx_valid_r && rx_ready);
			rx_data_r <= fifo_out_data;
		end
	end

	// Busy is back-pressure to the programmer, driven only in synchronous mode.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			busy_pin_r <= 1'b0;
			busy_pin_oe_r <= 1'b0;
		end else begin
			busy_pin_oe_r <= link_on && mode_sync_r;
			busy_pin_r <= link_on && mode_sync_r && (!fifo_in_ready || !tx_ready_r);
		end
	end

	// Transmit path: shifts on falling link clock edges or on the bit timer.
	assign tx_load = tx_valid && tx_ready_r;
	assign tx_tick = mode_sync_r ? clk_fall : (tx_tmr_r == BIT_LAST);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_ready_r <= 1'b0;
			tx_tmr_r <= '0;
			tx_cnt_r <= '0;
			tx_sh_r <= '1;
			serial_transmit_pin_r <= 1'b1;
		end else if (!link_on) begin
			tx_ready_r <= 1'b0;
		end else if (tx_load) begin
			tx_ready_r <= 1'b0;
			tx_tmr_r <= '0;
			tx_cnt_r <= mode_sync_r ? SYNC_FRAME_BITS : ASYNC_FRAME_BITS;
			tx_sh_r <= mode_sync_r ? {2'b11, tx_data} : {1'b1, tx_data, 1'b0};
		end else if (tx_cnt_r != '0) begin
			tx_tmr_r <= (tx_tmr_r == BIT_LAST) ? '0 : tx_tmr_r + 1'b1;
			if (tx_tick) begin
				serial_transmit_pin_r <= tx_sh_r[0];
				tx_sh_r <= {1'b1, tx_sh_r[ASYNC_FRAME_BITS-1:1]};
				tx_cnt_r <= tx_cnt_r - 1'b1;
			end
		end else begin
			tx_tmr_r <= (tx_tmr_r == BIT_LAST) ? '0 : tx_tmr_r + 1'b1;
			if (mode_sync_r) begin
				// The link clock rests high between frames, so waiting for a fall would stall the core.
				tx_ready_r <= 1'b1;
			end else if (tx_tick || tx_ready_r) begin
				// Final bit is held for a full bit time before the next load.
				tx_ready_r <= 1'b1;
				serial_transmit_pin_r <= 1'b1;
			end
		end
	end

	// Flash guard: boot area is never touched, user area is one block.
	assign in_boot = ({1'b0, fl_addr} >= {1'b0, BOOT_BASE}) &&
		({1'b0, fl_addr} < {1'b0, BOOT_BASE} + (ADDR_W+1)'(BOOT_AREA_BYTES));
	assign in_user = ({1'b0, fl_addr} >= {1'b0, USER_BASE}) &&
		({1'b0, fl_addr} < {1'b0, USER_BASE} + (ADDR_W+1)'(USER_AREA_BYTES));
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fl_go_r <= 1'b0;
			fl_erase_all_r <= 1'b0;
			fl_reject_r <= 1'b0;
		end else begin
			fl_go_r <= fl_req && link_on && in_user && !in_boot && !fl_erase;
			fl_erase_all_r <= fl_req && link_on && in_user && !in_boot && fl_erase;
			fl_reject_r <= fl_req && (!link_on || in_boot || !in_user);
		end
	end
endmodule // fbms_boot_ctrl

// *** rtl/fbms_pkg.sv ***
// Purpose: Shared constants for the serial flash boot mode selector.
// Assumes: System clock of 200 MHz.
// Notes: Times are kept in ns and turned into cycle counts here.
package fbms_pkg;
	localparam int unsigned CLK_PERIOD_NS = 5;
	// Default asynchronous bit time, 9600 baud.
	localparam int unsigned BIT_TIME_NS = 104167;
	localparam int unsigned BIT_CYCLES_DEF = BIT_TIME_NS / CLK_PERIOD_NS;
	// Cycles after reset release before pin levels are trusted.
	localparam logic [3:0] SETTLE_CYCLES = 4'h8;
	localparam int unsigned USER_AREA_BYTES = 24 * 1024;
	localparam int unsigned BOOT_AREA_BYTES = 384;
	localparam int unsigned FIFO_DEPTH_DEF = 16;
	localparam int unsigned DATA_W = 8;
	localparam logic [3:0] SYNC_FRAME_BITS = 4'h8;
	localparam logic [3:0] ASYNC_FRAME_BITS = 4'hA;
	localparam int unsigned PIN_BOOT = 0;
	localparam int unsigned PIN_CLK = 1;
	localparam int unsigned PIN_RX = 2;
	localparam int unsigned NUM_PINS = 3;
	typedef enum logic [1:0] {
		FBMS_MD_SETTLE = 2'b01,
		FBMS_MD_RUN = 2'b10
	} fbms_md_e;
	typedef enum logic [3:0] {
		FBMS_RX_IDLE = 4'b0001,
		FBMS_RX_START = 4'b0010,
		FBMS_RX_DATA = 4'b0100,
		FBMS_RX_STOP = 4'b1000
	} fbms_rx_e;
endpackage

// *** tb/fbms_chk.sv ***
// Purpose: Port checker for mode capture and the flash guard.
// Assumes: Straps stay steady through capture.
// Notes: Bound to every selector instance.
`timescale 1ns/100ps
module fbms_chk #(
	parameter int unsigned ADDR_W = 16,
	parameter logic [ADDR_W-1:0] USER_BASE = 16'h8000,
	parameter logic [ADDR_W-1:0] BOOT_BASE = 16'hF000
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Pins.
	input wire logic boot_select_pin,
	input wire logic serial_clock_pin,
	input wire logic serial_transmit_pin_r,
	input wire logic busy_pin_oe_r,
	// Mode.
	input wire logic mode_valid_r,
	input wire logic mode_serial_r,
	input wire logic mode_sync_r,
	// Flash guard.
	input wire logic fl_req,
	input wire logic fl_erase,
	input wire logic [ADDR_W-1:0] fl_addr,
	input wire logic fl_go_r,
	input wire logic fl_erase_all_r,
	input wire logic fl_reject_r
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic in_boot, in_user, live;
	assign in_boot = 32'(fl_addr) >= 32'(BOOT_BASE) && 32'(fl_addr) < 32'(BOOT_BASE) + 384;
	assign in_user = 32'(fl_addr) >= 32'(USER_BASE) && 32'(fl_addr) < 32'(USER_BASE) + 24576;
	assign live = mode_valid_r && mode_serial_r;
	mode_held_a: assert property (mode_valid_r |=> mode_valid_r && $stable(mode_serial_r) && $stable(mode_sync_r))
		else $error("mode changed after capture");
	boot_pick_a: assert property ($rose(mode_valid_r) |-> mode_serial_r == boot_select_pin)
		else $error("boot level not captured");
	sub_pick_a: assert property ($rose(mode_valid_r) && boot_select_pin |-> mode_sync_r == serial_clock_pin)
		else $error("submode not captured");
	busy_drive_a: assert property ($past(mode_valid_r, 2) |-> busy_pin_oe_r == (mode_serial_r && mode_sync_r))
		else $error("busy drive wrong for mode");
	one_answer_a: assert property (fl_req |=> $onehot({fl_go_r, fl_erase_all_r, fl_reject_r}))
		else $error("flash answer not single");
	quiet_guard_a: assert property (fl_go_r || fl_erase_all_r || fl_reject_r |-> $past(fl_req))
		else $error("flash answer without request");
	boot_guard_a: assert property (fl_req && in_boot |=> fl_reject_r)
		else $error("boot area not refused");
	user_erase_a: assert property (fl_req && fl_erase && in_user && live && $past(mode_valid_r) |=> fl_erase_all_r)
		else $error("user erase not whole block");
	user_prog_a: assert property (fl_req && !fl_erase && in_user && live && $past(mode_valid_r) |=> fl_go_r)
		else $error("user program not accepted");
	normal_refuse_a: assert property (fl_req && !mode_serial_r |=> fl_reject_r)
		else $error("request taken in normal mode");
	idle_line_a: assert property (!mode_serial_r |-> serial_transmit_pin_r)
		else $error("transmit line active in normal mode");
endmodule // fbms_chk
bind fbms_boot_ctrl fbms_chk #(.ADDR_W(ADDR_W), .USER_BASE(USER_BASE), .BOOT_BASE(BOOT_BASE)) chk (.sys_clk, .rst,
	.boot_select_pin, .serial_clock_pin, .serial_transmit_pin_r, .busy_pin_oe_r, .mode_valid_r, .mode_serial_r,
	.mode_sync_r, .fl_req, .fl_erase, .fl_addr, .fl_go_r, .fl_erase_all_r, .fl_reject_r);

// *** tb/fbms_prog.sv ***
// Purpose: External programmer model driving straps and the link.
// Assumes: Link clock of 64 ns, made only within frames.
// Notes: Receive line rests at mark level between frames.
`timescale 1ns/100ps
module fbms_prog (
	// Towards the device.
	output logic boot_select_pin,
	output logic serial_clock_pin,
	output logic serial_receive_pin,
	// From the device.
	input wire logic serial_transmit_pin_r
);
	initial begin
		boot_select_pin = 1'b0;
		serial_clock_pin = 1'b0;
		serial_receive_pin = 1'b1;
	end
	task automatic straps(input logic b, input logic c);
		boot_select_pin = b;
		serial_clock_pin = c;
	endtask
	// Clock stands high between frames; data set on falling, both sides sample on rising.
	task automatic sync_xfer(input logic [7:0] d, output logic [7:0] q);
		for (int i = 0; i < 8; i++) begin
			serial_clock_pin = 1'b0;
			serial_receive_pin = d[i];
			#32 serial_clock_pin = 1'b1;
			q[i] = serial_transmit_pin_r;
			#32;
		end
		serial_receive_pin = 1'b1;
	endtask
	task automatic async_send(input logic [7:0] d, input int bit_ns);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			serial_receive_pin = f[i];
			#(bit_ns);
		end
	endtask
	// Waits a bounded time for the start bit, then samples each data bit in its middle.
	task automatic async_recv(input int bit_ns, output logic [7:0] q);
		int n;
		n = 0;
		while (serial_transmit_pin_r !== 1'b0 && n < 1000) begin
			#1;
			n++;
		end
		#(bit_ns / 2);
		for (int i = 0; i < 8; i++) begin
			#(bit_ns);
			q[i] = serial_transmit_pin_r;
		end
		#(bit_ns);
	endtask
endmodule // fbms_prog

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the boot mode selector.
// Assumes: Short bit time of 16 cycles.
// Notes: Each scenario re-enters reset with new straps.
`timescale 1ns/100ps
module tb_top;
	import fbms_pkg::*;
	logic sys_clk, rst, rx_ready, tx_valid, fl_req, fl_erase;
	logic [7:0] tx_data, q;
	logic [15:0] fl_addr;
	wire logic boot, sclk, rxd, txd, busy, boe, mv, ms, msy, rxv, txr, go, eall, rej;
	wire logic [7:0] rdata;
	int err_count, comparisons;
	fbms_prog prog (.boot_select_pin(boot), .serial_clock_pin(sclk), .serial_receive_pin(rxd),
		.serial_transmit_pin_r(txd));
	fbms_boot_ctrl #(.BIT_CYCLES(16)) DUT (.sys_clk, .rst, .boot_select_pin(boot), .serial_clock_pin(sclk),
		.serial_receive_pin(rxd), .serial_transmit_pin_r(txd), .busy_pin_r(busy), .busy_pin_oe_r(boe),
		.mode_valid_r(mv), .mode_serial_r(ms), .mode_sync_r(msy), .rx_valid_r(rxv), .rx_data_r(rdata),
		.rx_ready, .tx_valid, .tx_data, .tx_ready_r(txr), .fl_req, .fl_erase, .fl_addr, .fl_go_r(go),
		.fl_erase_all_r(eall), .fl_reject_r(rej));
	task automatic wrap_up;
		if (err_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic limit(input int n, input int lim);
		if (n >= lim) begin
			err_count++;
			wrap_up;
		end
	endtask
	// Oscillator keeps running through a reset of twenty cycles.
	task automatic boot_with(input logic b, input logic c);
		int n;
		prog.straps(b, c);
		rst = 1'b1;
		repeat (20) tick;
		rst = 1'b0;
		n = 0;
		while (mv !== 1'b1 && n < 30) begin
			tick;
			n++;
		end
		limit(n, 30);
		repeat (2) tick;
		check(ms, b);
		check(msy, b && c);
		check(boe, b && c);
		check(busy, 1'b0);
	endtask
	task automatic load_tx(input logic [7:0] d);
		int n;
		n = 0;
		while (txr !== 1'b1 && n < 50) begin
			tick;
			n++;
		end
		limit(n, 50);
		tx_data = d;
		tx_valid = 1'b1;
		tick;
		tx_valid = 1'b0;
	endtask
	task automatic fl(input logic e, input logic [15:0] a, input logic [2:0] exp);
		fl_req = 1'b1;
		fl_erase = e;
		fl_addr = a;
		tick;
		check({go, eall, rej}, exp);
	endtask
	task automatic wait_rx(input logic [7:0] exp);
		int n;
		n = 0;
		tick;
		while (rxv !== 1'b1 && n < 400) begin
			tick;
			n++;
		end
		limit(n, 400);
		check(rdata, exp);
		rx_ready = 1'b1;
		tick;
		rx_ready = 1'b0;
		tick;
		check(rxv, 1'b0);
	endtask
	task automatic sc_normal;
		boot_with(1'b0, 1'b1);
		check(txd, 1'b1);
		check(txr, 1'b0);
		fl(1'b1, 16'h8000, 3'b001);
		fl_req = 1'b0;
	endtask
	task automatic sc_sync;
		boot_with(1'b1, 1'b1);
		fl(1'b1, 16'h8000, 3'b010);
		fl(1'b0, 16'h8010, 3'b100);
		fl(1'b0, 16'hDFFF, 3'b100);
		fl(1'b0, 16'hE000, 3'b001);
		fl(1'b0, 16'hF000, 3'b001);
		fl(1'b1, 16'hF17F, 3'b001);
		fl_req = 1'b0;
		load_tx(8'h3C);
		tick;
		check(busy, 1'b1);
		prog.sync_xfer(8'hA5, q);
		check(q, 8'h3C);
		wait_rx(8'hA5);
		check(msy, 1'b1);
	endtask
	task automatic sc_async;
		boot_with(1'b1, 1'b0);
		prog.async_send(8'h5A, 16 * 5);
		wait_rx(8'h5A);
		check(boe, 1'b0);
		load_tx(8'hC3);
		check(busy, 1'b0);
		prog.async_recv(16 * 5, q);
		check(q, 8'hC3);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial begin
		err_count = 0;
		comparisons = 0;
		rst = 1'b1;
		rx_ready = 1'b0;
		tx_valid = 1'b0;
		tx_data = 8'h00;
		fl_req = 1'b0;
		fl_erase = 1'b0;
		fl_addr = 16'h0000;
		repeat (2) tick;
		sc_normal;
		sc_sync;
		sc_async;
		wrap_up;
	end
endmodule // tb_top
